/* evl_pkg.sv */
// package for the code store verify and lock logic
package evl_pkg;
  localparam int unsigned ADDR_W      = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CODE_DEPTH  = 64;
  localparam int unsigned ENC_DEPTH   = 64;
  localparam int unsigned ENC_IDX_W   = 6;
  localparam int unsigned CODE_IDX_W  = 6;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [7:0]  SIG_ADDR_0  = 8'h30;
  localparam logic [7:0]  SIG_ADDR_1  = 8'h31;
  localparam logic [7:0]  SIG_ADDR_2  = 8'h60;
  // arbitrary neutral identity values
  localparam logic [7:0]  SIG_VAL_0   = 8'ha5;
  localparam logic [7:0]  SIG_VAL_1   = 8'h5a;
  localparam logic [7:0]  SIG_VAL_2   = 8'h3c;
  localparam int unsigned PULSES_CODE = 5;
  localparam int unsigned PULSES_LOCK = 25;
  localparam int unsigned PULSE_CNT_W = 5;

  // pin field positions on ports 2, 3
  localparam int unsigned P2_ADDR_HI  = 5;
  localparam int unsigned P2_CTL_A    = 6;
  localparam int unsigned P2_CTL_B    = 7;
  localparam int unsigned P3_ADDR_LO  = 4;
  localparam int unsigned P3_ADDR_HI  = 5;
  localparam int unsigned P3_CTL_C    = 3;
  localparam int unsigned P3_CTL_D    = 6;
  localparam int unsigned P3_CTL_E    = 7;

  typedef enum logic [2:0] {
    EVL_OP_NONE      = 3'h0,
    EVL_OP_PROGRAM_STROBE_CODE = 3'h1,
    EVL_OP_VERIFY    = 3'h2,
    EVL_OP_PROGRAM_STROBE_ENC  = 3'h3,
    EVL_OP_LOCK1     = 3'h4,
    EVL_OP_LOCK2     = 3'h5,
    EVL_OP_LOCK3     = 3'h6,
    EVL_OP_SIG       = 3'h7
  } evl_op_type;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [7:0] p0;
    logic       rst;
    logic       store_rd_n;
    logic       strobe_n;
    logic       ea_high;
    logic       vpp_high;
  } evl_pins_type;

  typedef struct packed {
    logic lock_bit_first;
    logic lock_bit_second;
    logic lock_bit_third;
  } evl_lock_type;
endpackage : evl_pkg

/* evl_mode_decode.sv */
// decoder of programming mode from control pins
`timescale 1ns/1ps
`default_nettype none
module evl_mode_decode
  import evl_pkg::*;
(
  input  wire evl_pkg::evl_pins_type pins_i,
  output var  evl_pkg::evl_op_type   op_o,
  output logic [ADDR_W-1:0]          addr_o
);
  logic [4:0] ctl;
  always_comb begin
    // address order P1, P2[5:0], P3[5:4]
    // 16 lines meet a 14-bit address: keep the low bits on purpose
    addr_o = ADDR_W'({pins_i.p3[P3_ADDR_HI:P3_ADDR_LO],
                      pins_i.p2[P2_ADDR_HI:0], pins_i.p1});
    ctl = {pins_i.p2[P2_CTL_A], pins_i.p2[P2_CTL_B], pins_i.p3[P3_CTL_C],
           pins_i.p3[P3_CTL_D], pins_i.p3[P3_CTL_E]};
    op_o = EVL_OP_NONE;
    if (pins_i.rst && !pins_i.store_rd_n) begin
      case (ctl)
        5'h0f: op_o = pins_i.vpp_high ? EVL_OP_PROGRAM_STROBE_CODE : EVL_OP_NONE;
        5'h03: op_o = EVL_OP_VERIFY;
        5'h0d: op_o = pins_i.vpp_high ? EVL_OP_PROGRAM_STROBE_ENC : EVL_OP_NONE;
        5'h1f: op_o = pins_i.vpp_high ? EVL_OP_LOCK1 : EVL_OP_NONE;
        5'h1c: op_o = pins_i.vpp_high ? EVL_OP_LOCK2 : EVL_OP_NONE;
        5'h16: op_o = pins_i.vpp_high ? EVL_OP_LOCK3 : EVL_OP_NONE;
        5'h00: op_o = EVL_OP_SIG;
        default: op_o = EVL_OP_NONE;
      endcase
    end
  end
endmodule // evl_mode_decode
`default_nettype wire

/* evl_core.sv */
// code store with encryption table, signature and lock levels
`timescale 1ns/1ps
`default_nettype none
module evl_core
  import evl_pkg::*;
#(
  parameter int unsigned CODE_WORDS = CODE_DEPTH
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire evl_pkg::evl_pins_type pins_i,
  input  wire logic                  erase_i,
  input  wire logic                  core_rst_i,
  input  wire logic                  ext_table_read_i,
  output logic [DATA_W-1:0]          p0_o,
  output logic                       p0_oe_n_o,
  output logic                       ea_latched_o,
  output logic                       table_read_block_o,
  output logic                       ext_exec_block_o,
  output var  evl_pkg::evl_lock_type lock_o
);
  import evl_pkg::*;

  evl_pins_type      s1_reg, s2_reg;
  evl_op_type        op;
  logic [ADDR_W-1:0] addr;

  // two-stage synchroniser for the programmer pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= pins_i;
      s2_reg <= s1_reg;
    end
  end

  evl_mode_decode u_dec (
    .pins_i (s2_reg),
    .op_o   (op),
    .addr_o (addr)
  );

  logic [DATA_W-1:0] code_reg [CODE_WORDS];
  logic [DATA_W-1:0] code_next[CODE_WORDS];
  logic [DATA_W-1:0] enc_reg  [ENC_DEPTH];
  logic [DATA_W-1:0] enc_next [ENC_DEPTH];
  evl_lock_type      lock_reg, lock_next;
  logic              strb_d_reg, strb_d_next;
  logic [PULSE_CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] p0_reg, p0_next;
  logic              oe_n_reg, oe_n_next;
  logic              ea_reg, ea_next, rst_d_reg, rst_d_next;

  logic [CODE_IDX_W-1:0] cidx;
  logic [ENC_IDX_W-1:0]  eidx;
  logic                  program_strobe_lock, verify_lock, fall, lock_op;
  logic [PULSE_CNT_W-1:0] need;

  always_comb begin
    cidx = addr[CODE_IDX_W-1:0];
    eidx = addr[ENC_IDX_W-1:0];
    program_strobe_lock = lock_reg.lock_bit_first;
    verify_lock = lock_reg.lock_bit_first && lock_reg.lock_bit_second;
    fall = strb_d_reg && !s2_reg.strobe_n;
    lock_op = (op == EVL_OP_PROGRAM_STROBE_ENC) || (op == EVL_OP_LOCK1) ||
              (op == EVL_OP_LOCK2) || (op == EVL_OP_LOCK3);
    need = lock_op ? PULSE_CNT_W'(PULSES_LOCK) : PULSE_CNT_W'(PULSES_CODE);
    code_next = code_reg;
    enc_next = enc_reg;
    lock_next = lock_reg;
    strb_d_next = s2_reg.strobe_n;
    cnt_next = cnt_reg;
    p0_next = '0;
    oe_n_next = 1'b1;
    rst_d_next = core_rst_i;
    ea_next = ea_reg;
    if (!rst_d_reg && core_rst_i)
      ea_next = s2_reg.ea_high;
    if (op == EVL_OP_NONE || op == EVL_OP_VERIFY || op == EVL_OP_SIG)
      cnt_next = '0;
    else if (fall && cnt_reg != need)
      cnt_next = cnt_reg + PULSE_CNT_W'(1);
    // programming cell: clear bits only, refused once locked
    if (fall && !program_strobe_lock) begin
      case (op)
        EVL_OP_PROGRAM_STROBE_CODE: code_next[cidx] = code_reg[cidx] & s2_reg.p0;
        EVL_OP_PROGRAM_STROBE_ENC:  enc_next[eidx] = enc_reg[eidx] & s2_reg.p0;
        default: ;
      endcase
    end
    // lock bits may be set even when locked, to raise the level
    if (fall) begin
      case (op)
        EVL_OP_LOCK1: lock_next.lock_bit_first = 1'b1;
        EVL_OP_LOCK2: lock_next.lock_bit_second = 1'b1;
        EVL_OP_LOCK3: lock_next.lock_bit_third = 1'b1;
        default: ;
      endcase
    end
    if (op == EVL_OP_VERIFY && !verify_lock) begin
      // xnor is identity against an erased entry
      p0_next = ~(code_reg[cidx] ^ enc_reg[eidx]);
      oe_n_next = 1'b0;
    end else if (op == EVL_OP_SIG) begin
      oe_n_next = 1'b0;
      case (addr[7:0])
        SIG_ADDR_0: p0_next = SIG_VAL_0;
        SIG_ADDR_1: p0_next = SIG_VAL_1;
        SIG_ADDR_2: p0_next = SIG_VAL_2;
        default:    p0_next = ERASED_BYTE;
      endcase
    end
    if (erase_i) begin
      for (int i = 0; i < int'(CODE_WORDS); i++) code_next[i] = ERASED_BYTE;
      for (int i = 0; i < int'(ENC_DEPTH); i++) enc_next[i] = ERASED_BYTE;
      lock_next = '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < int'(CODE_WORDS); i++) code_reg[i] <= ERASED_BYTE;
      for (int i = 0; i < int'(ENC_DEPTH); i++) enc_reg[i] <= ERASED_BYTE;
      lock_reg   <= '0;
      strb_d_reg <= 1'b1;
      cnt_reg    <= '0;
      p0_reg     <= '0;
      oe_n_reg   <= 1'b1;
      ea_reg     <= 1'b0;
      rst_d_reg  <= 1'b0;
    end else begin
      code_reg   <= code_next;
      enc_reg    <= enc_next;
      lock_reg   <= lock_next;
      strb_d_reg <= strb_d_next;
      cnt_reg    <= cnt_next;
      p0_reg     <= p0_next;
      oe_n_reg   <= oe_n_next;
      ea_reg     <= ea_next;
      rst_d_reg  <= rst_d_next;
    end
  end

  logic tb_reg, xb_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tb_reg <= 1'b0;
      xb_reg <= 1'b0;
    end else begin
      tb_reg <= ext_table_read_i && lock_reg.lock_bit_first;
      xb_reg <= lock_reg.lock_bit_first && lock_reg.lock_bit_second &&
                lock_reg.lock_bit_third;
    end
  end

  always_comb begin
    p0_o = p0_reg;
    p0_oe_n_o = oe_n_reg;
    ea_latched_o = ea_reg;
    table_read_block_o = tb_reg;
    ext_exec_block_o = xb_reg;
    lock_o = lock_reg;
  end

  property p_verify_xnor;
    @(posedge clk_i) disable iff (!resetn_i)
      (op == EVL_OP_VERIFY && !verify_lock && !erase_i) |=>
      p0_oe_n_o == 1'b0 &&
      p0_o == ~($past(code_reg[cidx]) ^ $past(enc_reg[eidx]));
  endproperty
  a_verify_xnor: assert property (p_verify_xnor)
    else $error("verify byte is not the xnor");
  property p_verify_blocked;
    @(posedge clk_i) disable iff (!resetn_i)
      (op == EVL_OP_VERIFY && verify_lock) |=> p0_oe_n_o && p0_o == 8'h00;
  endproperty
  a_verify_blocked: assert property (p_verify_blocked)
    else $error("verify answered while locked");
  property p_sig0;
    @(posedge clk_i) disable iff (!resetn_i)
      (op == EVL_OP_SIG && addr[7:0] == SIG_ADDR_0) |=> p0_o == SIG_VAL_0;
  endproperty
  a_sig0: assert property (p_sig0) else $error("bad signature 0");
  property p_program_strobe_refused;
    @(posedge clk_i) disable iff (!resetn_i)
      (program_strobe_lock && !erase_i) |=>
      code_reg[$past(cidx)] == $past(code_reg[cidx]);
  endproperty
  a_program_strobe_refused: assert property (p_program_strobe_refused)
    else $error("code changed while locked");
  property p_erase;
    @(posedge clk_i) disable iff (!resetn_i)
      erase_i |=> lock_reg == '0 && enc_reg[eidx] == ERASED_BYTE;
  endproperty
  a_erase: assert property (p_erase) else $error("erase incomplete");
  property p_exec_block;
    @(posedge clk_i) disable iff (!resetn_i)
      (lock_reg == 3'b111) |=> ext_exec_block_o;
  endproperty
  a_exec_block: assert property (p_exec_block)
    else $error("external execution not blocked");
  property p_unlocked_free;
    @(posedge clk_i) disable iff (!resetn_i)
      (lock_reg == 3'b000) |=> !ext_exec_block_o && !table_read_block_o;
  endproperty
  a_unlocked_free: assert property (p_unlocked_free)
    else $error("protection without lock");
  property p_cnt_cap;
    @(posedge clk_i) disable iff (!resetn_i) cnt_reg <= PULSE_CNT_W'(PULSES_LOCK);
  endproperty
  a_cnt_cap: assert property (p_cnt_cap) else $error("pulse count overflow");
  c_verify: cover property (@(posedge clk_i) op == EVL_OP_VERIFY ##1 !p0_oe_n_o);
  c_sig: cover property (@(posedge clk_i) op == EVL_OP_SIG);
  c_lock3: cover property (@(posedge clk_i) lock_reg == 3'b111);
endmodule // evl_core
`default_nettype wire

/* evl_programmer.sv */
// behavioural external programmer driving the programming pins
`timescale 1ns/1ps
`default_nettype none
module evl_programmer (
  input  wire logic                  clk_i,
  output var  evl_pkg::evl_pins_type pins_o
);
  import evl_pkg::*;

  initial begin
    pins_o            = '0;
    pins_o.store_rd_n = 1'b1;
    pins_o.strobe_n   = 1'b1;
  end

  // ctl is {p2.6, p2.7, p3.3, p3.6, p3.7}; lock levels are applied in order
  task automatic apply(input logic [4:0] ctl, input logic [13:0] addr,
                       input logic [7:0] data, input int pulses);
    @(posedge clk_i);
    pins_o.p1         <= addr[7:0];
    pins_o.p2         <= {ctl[3], ctl[4], addr[13:8]};
    pins_o.p3         <= {ctl[0], ctl[1], 2'h0, ctl[2], 3'h0};
    // a released data bus shows the inverse of the last byte
    pins_o.p0         <= (pulses > 0) ? data : ~pins_o.p0;
    pins_o.rst        <= 1'b1;
    pins_o.store_rd_n <= 1'b0;
    pins_o.ea_high    <= 1'b1;
    pins_o.vpp_high   <= (pulses > 0);
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < pulses; i++) begin
      pins_o.strobe_n <= 1'b0;
      repeat (2) @(posedge clk_i);
      pins_o.strobe_n <= 1'b1;
      repeat (2) @(posedge clk_i);
    end
    if (pulses > 0) begin
      repeat (4) @(posedge clk_i);
      pins_o.vpp_high <= 1'b0;
    end
  endtask
endmodule // evl_programmer
`default_nettype wire

/* tb_eprom_verify_lock_logic.sv */
// self-checking bench for the code store verify and lock logic
`timescale 1ns/1ps
`default_nettype none
module tb_eprom_verify_lock_logic;
  import evl_pkg::*;
  localparam logic [4:0] C_CODE = 5'h0f;
  localparam logic [4:0] C_VER  = 5'h03;
  localparam logic [4:0] C_ENC  = 5'h0d;
  localparam logic [4:0] C_LK1  = 5'h1f;
  localparam logic [4:0] C_LK2  = 5'h1c;
  localparam logic [4:0] C_LK3  = 5'h16;
  localparam logic [4:0] C_SIG  = 5'h00;

  logic                clk_i = 1'b0;
  logic                resetn_i = 1'b0;
  logic                erase_i = 1'b0;
  logic                core_rst_i = 1'b0;
  logic                ext_table_read_i = 1'b0;
  evl_pins_type        pins;
  logic [DATA_W-1:0]   p0_o;
  logic                p0_oe_n_o;
  logic                ea_latched_o;
  logic                table_read_block_o;
  logic                ext_exec_block_o;
  evl_lock_type        lock_o;
  int                  error_cnt = 0;
  int                  compares = 0;

  always #12.5 clk_i = ~clk_i;

  evl_programmer PRG (.clk_i(clk_i), .pins_o(pins));

  evl_core #(.CODE_WORDS(64)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins), .erase_i(erase_i),
    .core_rst_i(core_rst_i), .ext_table_read_i(ext_table_read_i),
    .p0_o(p0_o), .p0_oe_n_o(p0_oe_n_o), .ea_latched_o(ea_latched_o),
    .table_read_block_o(table_read_block_o),
    .ext_exec_block_o(ext_exec_block_o), .lock_o(lock_o));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic verify(input logic [4:0] ctl, input logic [13:0] a,
                        input logic [7:0] d, input logic oe_n);
    PRG.apply(ctl, a, 8'h00, 0);
    repeat (4) @(posedge clk_i);
    #1;
    chk("verify data", d, p0_o);
    chk("verify oe_n", {7'h0, oe_n}, {7'h0, p0_oe_n_o});
  endtask

  task automatic lvl(input logic [2:0] e);
    repeat (4) @(posedge clk_i);
    #1;
    chk("lock", {5'h0, e}, {5'h0, lock_o});
  endtask

  task automatic t_erased;
    chk("idle oe_n", 8'h01, {7'h0, p0_oe_n_o});
    lvl(3'b000);
    verify(C_VER, 14'h0005, ERASED_BYTE, 1'b0);
    verify(C_SIG, 14'h0030, SIG_VAL_0, 1'b0);
    verify(C_SIG, 14'h0031, SIG_VAL_1, 1'b0);
    verify(C_SIG, 14'h0060, SIG_VAL_2, 1'b0);
    verify(C_SIG, 14'h0040, ERASED_BYTE, 1'b0);
  endtask

  task automatic t_encrypt;
    PRG.apply(C_CODE, 14'h2a05, 8'h3a, PULSES_CODE);
    verify(C_VER, 14'h2a05, 8'h3a, 1'b0);
    PRG.apply(C_ENC, 14'h0025, 8'hf0, PULSES_LOCK);
    PRG.apply(C_ENC, 14'h0005, 8'h0f, PULSES_LOCK);
    verify(C_VER, 14'h2a05, ~(8'h3a ^ 8'h0f), 1'b0);
    verify(C_VER, 14'h0025, ~(8'hff ^ 8'hf0), 1'b0);
  endtask

  task automatic t_lock1;
    @(posedge clk_i);
    ext_table_read_i <= 1'b1;
    PRG.apply(C_LK1, 14'h0000, 8'h00, PULSES_LOCK);
    lvl(3'b100);
    chk("table block", 8'h01, {7'h0, table_read_block_o});
    @(posedge clk_i);
    ext_table_read_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("table block off", 8'h00, {7'h0, table_read_block_o});
    PRG.apply(C_CODE, 14'h0006, 8'h00, PULSES_CODE);
    verify(C_VER, 14'h0006, ERASED_BYTE, 1'b0);
    @(posedge clk_i) core_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk("ea latched", 8'h01, {7'h0, ea_latched_o});
    @(posedge clk_i);
    core_rst_i <= 1'b0;
  endtask

  task automatic t_lock23;
    PRG.apply(C_LK2, 14'h0000, 8'h00, PULSES_LOCK);
    lvl(3'b110);
    verify(C_VER, 14'h2a05, 8'h00, 1'b1);
    chk("exec block", 8'h00, {7'h0, ext_exec_block_o});
    PRG.apply(C_LK3, 14'h0000, 8'h00, PULSES_LOCK);
    lvl(3'b111);
    chk("exec block", 8'h01, {7'h0, ext_exec_block_o});
  endtask

  task automatic t_erase;
    @(posedge clk_i) erase_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    erase_i <= 1'b0;
    lvl(3'b000);
    chk("exec block", 8'h00, {7'h0, ext_exec_block_o});
    verify(C_VER, 14'h2a05, ERASED_BYTE, 1'b0);
    verify(C_VER, 14'h0025, ERASED_BYTE, 1'b0);
  endtask

  task automatic summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_erased;
    t_encrypt;
    t_lock1;
    t_lock23;
    t_erase;
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    summarize;
  end
endmodule // tb_eprom_verify_lock_logic
`default_nettype wire
